// >>> dgtc_pkg.sv
// Constants, register map and types of the dual general-purpose counter.
package dgtc_pkg;

  // **********************************************************
  // Sizes and timing
  // **********************************************************
  localparam int NCH         = 2;
  localparam int CW          = 16;
  localparam int PCLK_HZ     = 100_000_000;
  localparam int INT_TICK_HZ = 10_000_000;
  localparam int INT_DIV     = PCLK_HZ / INT_TICK_HZ;

  // **********************************************************
  // Register map, byte addresses
  // **********************************************************
  localparam logic [7:0] CH_STRIDE = 8'h20;
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_INIT  = 8'h04;
  localparam logic [7:0] OFS_DLY   = 8'h08;
  localparam logic [7:0] OFS_WID   = 8'h0C;
  localparam logic [7:0] OFS_CMD   = 8'h10;
  localparam logic [7:0] OFS_CNT   = 8'h14;
  localparam logic [7:0] OFS_STAT  = 8'h40;
  localparam logic [7:0] OFS_MASK  = 8'h44;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_RESET_BIT = 1;

  // **********************************************************
  // Operating modes, field mode of the control register
  // **********************************************************
  localparam logic [2:0] M_COUNT  = 3'h0;
  localparam logic [2:0] M_PERIOD = 3'h1;
  localparam logic [2:0] M_WIDTH  = 3'h2;
  localparam logic [2:0] M_GSNGL  = 3'h3;
  localparam logic [2:0] M_TSNGL  = 3'h4;
  localparam logic [2:0] M_RETRIG = 3'h5;
  localparam logic [2:0] M_TCONT  = 3'h6;
  localparam logic [2:0] M_GCONT  = 3'h7;

  // Channel states, Gray coded along idle, armed, run, high, done.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ARMED = 3'h1,
    ST_RUN   = 3'h3,
    ST_HIGH  = 3'h2,
    ST_DONE  = 3'h6
  } dgtc_state_e;

  // Control register fields, bit 0 upward is mode.
  typedef struct packed {
    logic       gate_sw_lvl;
    logic       gate_sw_en;
    logic       dir_sw_up;
    logic       dir_sw_en;
    logic       pol_out;
    logic       pol_dir;
    logic       pol_gate;
    logic       pol_clk;
    logic       clk_ext;
    logic [2:0] mode;
  } dgtc_ctrl_s;

  localparam int         CTRL_W   = 12;
  localparam dgtc_ctrl_s CTRL_RST = 12'h000;
  localparam logic [CW-1:0] CNT_RST = 16'h0000;
  localparam logic [CW-1:0] CNT_ONE = 16'h0001;

endpackage

// >>> dgtc_top.sv
// Dual 16-bit general-purpose up/down timer/counter with APB registers.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`default_nettype none

module dgtc_top
  import dgtc_pkg::*;
#(
  parameter int INT_DIV_P = dgtc_pkg::INT_DIV
) (
  // Clock and reset.
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // APB slave.
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Counter pins, one bit per channel.
  input  wire logic [dgtc_pkg::NCH-1:0]  count_clock_in,
  input  wire logic [dgtc_pkg::NCH-1:0]  gate_in,
  input  wire logic [dgtc_pkg::NCH-1:0]  direction_in,
  output logic      [dgtc_pkg::NCH-1:0]  pulse_out,
  // Interrupt.
  output logic                           irq
);
  import dgtc_pkg::*;

  // **********************************************************
  // Register storage and channel state
  // **********************************************************
  dgtc_ctrl_s    ctrl  [NCH];
  logic [CW-1:0] init  [NCH];
  logic [CW-1:0] dly   [NCH];
  logic [CW-1:0] wid   [NCH];
  logic [CW-1:0] cnt   [NCH];
  dgtc_state_e   st    [NCH];
  logic [NCH-1:0] clk_q;
  logic [NCH-1:0] gate_q;
  logic [NCH-1:0] evt;
  logic [NCH-1:0] out_nxt;
  logic [NCH-1:0] status;
  logic [NCH-1:0] mask;
  logic [7:0]     div_cnt;
  logic           int_tick;

  // **********************************************************
  // APB decode
  // **********************************************************

  // Address split into channel select and offset within a channel.
  wire logic       wr_en   = psel & penable & pready & pwrite;
  wire logic       setup   = psel & ~penable;
  wire logic       in_ch   = paddr < OFS_STAT;
  wire logic       rsel    = |(paddr & CH_STRIDE);
  wire logic [7:0] ofs     = paddr & ~CH_STRIDE;
  wire logic       aligned = paddr[1:0] == 2'h0;
  wire logic       mapped  = aligned & (in_ch ? (ofs <= OFS_CNT) :
                             (paddr == OFS_STAT || paddr == OFS_MASK));
  wire logic       wr_stat = wr_en & (paddr == OFS_STAT);
  wire logic       wr_mask = wr_en & (paddr == OFS_MASK);

  // Read selection of the addressed register, zero above used bits.
  wire logic [31:0] rd_ch =
      (ofs == OFS_CTRL) ? {20'h0_0000, ctrl[rsel]} :
      (ofs == OFS_INIT) ? {16'h0000, init[rsel]} :
      (ofs == OFS_DLY)  ? {16'h0000, dly[rsel]} :
      (ofs == OFS_WID)  ? {16'h0000, wid[rsel]} :
      (ofs == OFS_CNT)  ? {16'h0000, cnt[rsel]} : 32'h0000_0000;
  wire logic [31:0] rd_data =
      !mapped              ? 32'h0000_0000 :
      in_ch                ? rd_ch :
      (paddr == OFS_STAT)  ? 32'(status) :
      32'(mask);

  // Answer in the first access cycle; unmapped offsets raise pslverr.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      prdata  <= (setup & ~pwrite) ? rd_data : 32'h0000_0000;
      pslverr <= setup & ~mapped;
    end
  end

  // **********************************************************
  // Internal count clock
  // **********************************************************

  // Divider making a one-cycle tick at the internal count rate.
  assign int_tick = div_cnt == 8'(INT_DIV_P - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= int_tick ? 8'h00 : div_cnt + 8'h01;
    end
  end

  // **********************************************************
  // Interrupt status and mask
  // **********************************************************

  // Sticky events; a new event in the clearing cycle still sets the bit.
  wire logic [NCH-1:0] next_status =
      (status & ~(wr_stat ? pwdata[NCH-1:0] : {NCH{1'b0}})) | evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status    <= {NCH{1'b0}};
      mask      <= {NCH{1'b0}};
      irq       <= 1'b0;
      pulse_out <= {NCH{1'b0}};
    end else begin
      status    <= next_status;
      mask      <= wr_mask ? pwdata[NCH-1:0] : mask;
      irq       <= |(status & mask);
      pulse_out <= out_nxt;
    end
  end

  // **********************************************************
  // Channels
  // **********************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      // Per-channel register strobes.
      wire logic sel_me  = wr_en & in_ch & (rsel == 1'(g));
      wire logic wr_cmd  = sel_me & (ofs == OFS_CMD);
      wire logic c_start = wr_cmd & pwdata[CMD_START_BIT];
      wire logic c_reset = wr_cmd & pwdata[CMD_RESET_BIT];
      wire logic any_cmd = c_start | c_reset;
      wire logic [2:0] m = ctrl[g].mode;

      // Input senses with programmable polarity.
      wire logic clk_lvl  = count_clock_in[g] ^ ctrl[g].pol_clk;
      wire logic gate_lvl = ctrl[g].gate_sw_en ? ctrl[g].gate_sw_lvl :
                            gate_in[g] ^ ctrl[g].pol_gate;
      wire logic up       = ctrl[g].dir_sw_en ? ctrl[g].dir_sw_up :
                            direction_in[g] ^ ctrl[g].pol_dir;

      // Active count-clock edge from the pin or the internal divider.
      wire logic tick = ctrl[g].clk_ext ? (clk_lvl & ~clk_q[g]) :
                        int_tick;
      wire logic gate_edge = gate_lvl & ~gate_q[g];

      // Mode classes and the gated advance of pulse counting.
      wire logic is_pulse = m >= M_GSNGL;
      wire logic gated    = (m == M_GSNGL) || (m == M_GCONT);
      wire logic adv      = tick & (~gated | gate_lvl);
      wire logic [CW-1:0] step = up ? cnt[g] + CNT_ONE :
                                      cnt[g] - CNT_ONE;
      wire logic [CW-1:0] dly_eff = (dly[g] == CNT_RST) ? CNT_ONE : dly[g];
      wire logic [CW-1:0] wid_eff = (wid[g] == CNT_RST) ? CNT_ONE : wid[g];
      wire logic last = cnt[g] <= CNT_ONE;

      dgtc_state_e   next_st;
      logic [CW-1:0] next_cnt;
      logic          next_evt;

      // Raw output: high during a pulse, or held high after measuring.
      assign out_nxt[g] = ctrl[g].pol_out ^ ((st[g] == ST_HIGH) ||
                          (st[g] == ST_DONE && !is_pulse));
      assign evt[g] = next_evt;

      // Channel sequencer; start wins over reset in the same write.
      always_comb begin
        next_st  = st[g];
        next_cnt = cnt[g];
        next_evt = 1'b0;
        if (c_start) begin
          next_cnt = is_pulse ? dly_eff : init[g];
          if (m == M_COUNT || gated) begin
            next_st = ST_RUN;
          end else begin
            next_st = ST_ARMED;
          end
        end else if (c_reset) begin
          next_st  = ST_IDLE;
          next_cnt = init[g];
        end else begin
          case (st[g])
            ST_ARMED: begin
              if (gate_edge) begin
                next_st = ST_RUN;
                if (is_pulse) begin
                  next_cnt = dly_eff;
                end
              end
            end
            ST_RUN: begin
              if (is_pulse) begin
                if (adv) begin
                  next_cnt = last ? wid_eff : cnt[g] - CNT_ONE;
                  if (last) begin
                    next_st = ST_HIGH;
                  end
                end
              end else if (m == M_COUNT) begin
                if (gate_lvl && tick) begin
                  next_cnt = step;
                end
              end else if (m == M_PERIOD) begin
                if (tick) begin
                  next_cnt = step;
                end
                if (gate_edge) begin
                  next_st  = ST_DONE;
                  next_evt = 1'b1;
                end
              end else if (!gate_lvl) begin
                next_st  = ST_DONE;
                next_evt = 1'b1;
              end else if (tick) begin
                next_cnt = step;
              end
            end
            ST_HIGH: begin
              if (adv) begin
                next_cnt = cnt[g] - CNT_ONE;
                if (last) begin
                  next_evt = 1'b1;
                  case (m)
                    M_RETRIG: next_st = ST_ARMED;
                    M_TCONT, M_GCONT: begin
                      next_st  = ST_RUN;
                      next_cnt = dly_eff;
                    end
                    default: next_st = ST_DONE;
                  endcase
                end
              end
            end
            default: next_st = st[g];
          endcase
        end
      end

      // Channel registers and input history.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctrl[g]   <= CTRL_RST;
          init[g]   <= CNT_RST;
          dly[g]    <= CNT_RST;
          wid[g]    <= CNT_RST;
          cnt[g]    <= CNT_RST;
          st[g]     <= ST_IDLE;
          clk_q[g]  <= 1'b0;
          gate_q[g] <= 1'b0;
        end else begin
          if (sel_me && ofs == OFS_CTRL) begin
            ctrl[g] <= dgtc_ctrl_s'(pwdata[CTRL_W-1:0]);
          end
          if (sel_me && ofs == OFS_INIT) begin
            init[g] <= pwdata[CW-1:0];
          end
          if (sel_me && ofs == OFS_DLY) begin
            dly[g] <= pwdata[CW-1:0];
          end
          if (sel_me && ofs == OFS_WID) begin
            wid[g] <= pwdata[CW-1:0];
          end
          cnt[g]    <= next_cnt;
          st[g]     <= next_st;
          clk_q[g]  <= clk_lvl;
          gate_q[g] <= gate_lvl;
        end
      end

      // Checks of channel behaviour.
      out_low_a: assert property (
        st[g] == ST_IDLE && $past(st[g]) == ST_IDLE && !$past(ctrl[g].pol_out)
        |-> pulse_out[g] == 1'b0)
        else $error("Idle pulse output is not low.");
      stay_idle_a: assert property (
        st[g] == ST_IDLE && !c_start |=> st[g] == ST_IDLE)
        else $error("Channel left idle without start.");
      sw_reload_a: assert property (
        c_reset && !c_start |=> st[g] == ST_IDLE && cnt[g] == $past(init[g]))
        else $error("Software reset did not reload the count.");
      gate_hold_a: assert property (
        st[g] == ST_RUN && m == M_COUNT && !gate_lvl && !any_cmd
        |=> $stable(cnt[g]))
        else $error("Count moved while gate inactive.");
      count_up_a: assert property (
        st[g] == ST_RUN && m == M_COUNT && gate_lvl && tick && up &&
        !any_cmd |=> cnt[g] == $past(cnt[g]) + CNT_ONE)
        else $error("Count did not step up on a clock edge.");
      period_end_a: assert property (
        st[g] == ST_RUN && m == M_PERIOD && gate_edge && !any_cmd
        |=> st[g] == ST_DONE ##1 pulse_out[g] == ~ctrl[g].pol_out)
        else $error("Period end did not raise the output.");
      width_end_a: assert property (
        st[g] == ST_RUN && m == M_WIDTH && !gate_lvl && !any_cmd
        |=> st[g] == ST_DONE)
        else $error("Pulse-width end not detected.");
      delay_end_a: assert property (
        st[g] == ST_RUN && is_pulse && adv && last && !any_cmd
        |=> st[g] == ST_HIGH && cnt[g] == $past(wid_eff))
        else $error("Delay end did not start the pulse.");
      one_shot_a: assert property (
        st[g] == ST_DONE && m == M_TSNGL && !any_cmd |=> st[g] == ST_DONE)
        else $error("Single trigger fired again.");
      retrig_busy_a: assert property (
        st[g] == ST_HIGH && m == M_RETRIG && !last && !any_cmd
        |=> st[g] == ST_HIGH)
        else $error("Retrigger disturbed a running pulse.");
      train_loop_a: assert property (
        st[g] == ST_HIGH && m == M_TCONT && adv && last && !any_cmd
        |=> st[g] == ST_RUN && cnt[g] == $past(dly_eff))
        else $error("Continuous train did not restart.");
      meas_freeze_a: assert property (
        st[g] == ST_DONE && !is_pulse && !any_cmd
        |=> st[g] == ST_DONE && $stable(cnt[g]))
        else $error("Measurement result not frozen.");
    end
  endgenerate

  irq_level_a: assert property (
    |(status & mask) |=> irq)
    else $error("Interrupt not raised for unmasked status.");

endmodule

`default_nettype wire

// >>> dgtc_sig_src.sv
// Far-side model driving count clock, gate and direction pins.
`timescale 1ns/1ns
`default_nettype none

module dgtc_sig_src #(
  parameter int HALF = 5
) (
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Requests from the bench.
  input  wire logic [7:0] burst_len,
  input  wire logic       burst_go,
  input  wire logic [1:0] gate_lvl,
  input  wire logic [1:0] dir_lvl,
  // Pins toward the counter.
  output logic      [1:0] count_clock_in,
  output logic      [1:0] gate_in,
  output logic      [1:0] direction_in,
  output logic            busy
);
  // ********
  // Burst clock
  // ********
  logic [8:0] edges_left;
  logic [3:0] phase;

  // The clock rests low between bursts and runs at 10 MHz inside one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edges_left     <= '0;
      phase          <= '0;
      count_clock_in <= '0;
    end else if (burst_go && edges_left == 9'h000) begin
      edges_left <= {burst_len, 1'b0};
      phase      <= '0;
    end else if (edges_left != 9'h000) begin
      if (phase == 4'(HALF - 1)) begin
        phase             <= '0;
        count_clock_in[0] <= ~count_clock_in[0];
        edges_left        <= edges_left - 9'h001;
      end else begin
        phase <= phase + 4'h1;
      end
    end
  end

  // Gate and direction follow the bench's chosen levels.
  assign gate_in      = gate_lvl;
  assign direction_in = dir_lvl;
  assign busy         = (edges_left != 9'h000) || burst_go;
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the dual general-purpose counter.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import dgtc_pkg::*;
  // ********
  // Signals
  // ********
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, burst_len;
  logic [31:0] pwdata, prdata, rd, c0;
  logic [1:0]  count_clock_in, gate_in, direction_in, pulse_out;
  logic [1:0]  gate_lvl, dir_lvl;
  logic        irq, burst_go, busy, err;
  int          n_fail, compares, cyc;

  dgtc_top #(.INT_DIV_P(2)) u_dgtc_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_clock_in(count_clock_in), .gate_in(gate_in),
    .direction_in(direction_in), .pulse_out(pulse_out), .irq(irq));
  dgtc_sig_src u_dgtc_sig_src (.pclk(pclk), .presetn(presetn),
    .burst_len(burst_len), .burst_go(burst_go), .gate_lvl(gate_lvl),
    .dir_lvl(dir_lvl), .count_clock_in(count_clock_in), .gate_in(gate_in),
    .direction_in(direction_in), .busy(busy));

  // Free-running 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Cuts a hang short.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ********
  // Tasks
  // ********
  task automatic tally_and_finish;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) n_fail++;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input string w);
    apb(1'b0, a, 32'h0000_0000);
    chk(w, e, rd);
  endtask

  // Sets the gate, sends n clock pulses, then checks the output level.
  task automatic step(input logic g, input int n, input logic e,
                      input string w);
    int k;
    k = 0;
    gate_lvl[0] <= g;
    repeat (4) @(posedge pclk);
    burst_len <= 8'(n);
    burst_go  <= 1'b1;
    @(posedge pclk);
    burst_go <= 1'b0;
    repeat (2) @(posedge pclk);
    while (busy && k < 3000) begin
      k++;
      @(posedge pclk);
    end
    if (k >= 3000) n_fail++;
    repeat (6) @(posedge pclk);
    chk(w, 32'(e), 32'(pulse_out[0]));
  endtask

  task automatic cfg(input logic [11:0] c, input logic [15:0] ini,
                     input logic [15:0] dl, input logic [15:0] wd,
                     input logic go);
    apb(1'b1, OFS_CMD, 32'h0000_0002);
    apb(1'b1, OFS_CTRL, 32'(c));
    apb(1'b1, OFS_INIT, 32'(ini));
    apb(1'b1, OFS_DLY, 32'(dl));
    apb(1'b1, OFS_WID, 32'(wd));
    apb(1'b1, OFS_CMD, 32'h0000_0002 | 32'(go));
  endtask

  // ********
  // Main sequence
  // ********
  initial begin
    {presetn, psel, penable, pwrite, burst_go} = '0;
    {paddr, pwdata, burst_len, gate_lvl, dir_lvl} = '0;
    {n_fail, compares, cyc} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk("pulse_out", 32'h0000_0000, 32'(pulse_out));
    chk("irq", 32'h0000_0000, 32'(irq));
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, 32'(err));
    gate_lvl <= 2'b01;
    cfg({9'h001, M_COUNT}, 16'h0005, 16'h0000, 16'h0000, 1'b0);
    rdchk(OFS_CNT, 32'h0000_0005, "cnt");
    step(1'b1, 3, 1'b0, "out");
    rdchk(OFS_CNT, 32'h0000_0005, "cnt idle");
    apb(1'b1, OFS_CMD, 32'h0000_0001);
    step(1'b1, 3, 1'b0, "out");
    rdchk(OFS_CNT, 32'h0000_0002, "cnt down");
    step(1'b0, 2, 1'b0, "out");
    rdchk(OFS_CNT, 32'h0000_0002, "cnt gated");
    dir_lvl <= 2'b01;
    step(1'b1, 4, 1'b0, "out");
    rdchk(OFS_CNT, 32'h0000_0006, "cnt up");
    apb(1'b1, OFS_CTRL, 32'h0000_0028);
    step(1'b0, 1, 1'b0, "out");
    rdchk(OFS_CNT, 32'h0000_0007, "cnt gate low");
    apb(1'b1, OFS_CMD, 32'h0000_0002);
    step(1'b0, 2, 1'b0, "out");
    rdchk(OFS_CNT, 32'h0000_0005, "cnt reset");
    gate_lvl <= 2'b01;
    cfg({9'h000, M_COUNT}, 16'h0000, 16'h0000, 16'h0000, 1'b1);
    apb(1'b0, OFS_CNT, 32'h0000_0000);
    c0 = rd;
    repeat (20) @(posedge pclk);
    apb(1'b0, OFS_CNT, 32'h0000_0000);
    chk("cnt internal", 32'h0000_0001, 32'(rd > c0));
    c0 = rd;
    apb(1'b1, OFS_INIT + CH_STRIDE, 32'h0000_1234);
    apb(1'b1, OFS_CMD + CH_STRIDE, 32'h0000_0002);
    rdchk(OFS_CNT + CH_STRIDE, 32'h0000_1234, "cnt1");
    apb(1'b0, OFS_CNT, 32'h0000_0000);
    chk("cnt0 runs", 32'h0000_0001, 32'(rd > c0));
    gate_lvl <= 2'b00;
    cfg({9'h001, M_PERIOD}, 16'h0000, 16'h0000, 16'h0000, 1'b1);
    step(1'b1, 4, 1'b0, "period out");
    step(1'b0, 0, 1'b0, "period out");
    step(1'b1, 0, 1'b1, "period out");
    rdchk(OFS_CNT, 32'h0000_0004, "period cnt");
    step(1'b1, 3, 1'b1, "held out");
    rdchk(OFS_CNT, 32'h0000_0004, "held cnt");
    rdchk(OFS_STAT, 32'h0000_0001, "status");
    chk("irq masked", 32'h0000_0000, 32'(irq));
    apb(1'b1, OFS_MASK, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h0000_0001, 32'(irq));
    apb(1'b1, OFS_STAT, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0000_0000, 32'(irq));
    rdchk(OFS_STAT, 32'h0000_0000, "status cleared");
    gate_lvl <= 2'b00;
    cfg({9'h001, M_WIDTH}, 16'h0000, 16'h0000, 16'h0000, 1'b1);
    step(1'b1, 3, 1'b0, "width out");
    step(1'b0, 0, 1'b1, "width out");
    rdchk(OFS_CNT, 32'h0000_0003, "width cnt");
    gate_lvl <= 2'b01;
    cfg({9'h001, M_GSNGL}, 16'h0000, 16'h0002, 16'h0004, 1'b1);
    step(1'b1, 1, 1'b0, "gsngl");
    step(1'b1, 1, 1'b1, "gsngl");
    step(1'b0, 4, 1'b1, "gsngl paused");
    step(1'b1, 3, 1'b1, "gsngl");
    step(1'b1, 1, 1'b0, "gsngl end");
    step(1'b1, 8, 1'b0, "gsngl once");
    gate_lvl <= 2'b00;
    cfg({9'h001, M_TSNGL}, 16'h0000, 16'h0002, 16'h0004, 1'b1);
    step(1'b0, 3, 1'b0, "tsngl wait");
    step(1'b1, 2, 1'b1, "tsngl");
    step(1'b1, 4, 1'b0, "tsngl end");
    step(1'b0, 0, 1'b0, "tsngl");
    step(1'b1, 8, 1'b0, "tsngl ignored");
    gate_lvl <= 2'b00;
    cfg({9'h001, M_RETRIG}, 16'h0000, 16'h0002, 16'h0004, 1'b1);
    step(1'b1, 2, 1'b1, "retrig");
    step(1'b0, 0, 1'b1, "retrig");
    step(1'b1, 4, 1'b0, "retrig end");
    step(1'b1, 2, 1'b0, "retrig ignored");
    step(1'b0, 0, 1'b0, "retrig");
    step(1'b1, 2, 1'b1, "retrig again");
    gate_lvl <= 2'b00;
    cfg({9'h001, M_TCONT}, 16'h0000, 16'h0004, 16'h0003, 1'b1);
    step(1'b0, 5, 1'b0, "tcont wait");
    step(1'b1, 4, 1'b1, "tcont");
    step(1'b0, 3, 1'b0, "tcont");
    step(1'b1, 4, 1'b1, "tcont train");
    gate_lvl <= 2'b01;
    cfg({9'h001, M_GCONT}, 16'h0000, 16'h0004, 16'h0003, 1'b1);
    step(1'b1, 4, 1'b1, "gcont");
    step(1'b1, 3, 1'b0, "gcont");
    step(1'b0, 6, 1'b0, "gcont paused");
    step(1'b1, 4, 1'b1, "gcont again");
    // Falling count-clock edges and inverted direction pin count down.
    cfg({9'h00B, M_COUNT}, 16'h0010, 16'h0000, 16'h0000, 1'b1);
    step(1'b1, 3, 1'b0, "out");
    rdchk(OFS_CNT, 32'h0000_000D, "cnt clk dir inverted");
    // Software gate and software direction override the pins.
    cfg({9'h1A1, M_COUNT}, 16'h0010, 16'h0000, 16'h0000, 1'b1);
    step(1'b0, 2, 1'b0, "out");
    rdchk(OFS_CNT, 32'h0000_000E, "cnt software dir gate");
    cfg({9'h010, M_COUNT}, 16'h0000, 16'h0000, 16'h0000, 1'b0);
    repeat (3) @(posedge pclk);
    chk("inverted idle", 32'h0000_0001, 32'(pulse_out));
    tally_and_finish();
  end
endmodule
`default_nettype wire
